// *** hdl/colour_matrix_mode_select.sv ***
// colour matrix: mode selection, register page and 3x3 pixel path
// assumes a register port already decoded from the serial bus and a
// pixel stream on core_clk; channel a carries luma in YPbPr output
//
// Functional notes
// (RULE1) force clear: enable only when work needed
// (RULE2) force set: matrix always enabled
// (RULE3) mode 0000 manual, 1111 automatic, reset 1111
// (RULE4) auto conversion from format, space, swap
// (RULE5) auto coefficients and offsets use range select; code uses fixed tables and offsets whatever the range
// (RULE6) software programs input and output space
// (RULE7) manual mode uses software coefficients only
// (RULE8) input format codes force space and range
// (RULE9) format 1111 follows link reported colour space
// (RULE10) software never writes formats 1000 to 1110
// (RULE11) link modes 0101/0110: yuv full, rgb reported
// (RULE12) space bit picks YPbPr/RGB and blank levels
// (RULE13) swap bit exchanges 601 and 709
// (RULE14) rgb output wins over format and swap
// (RULE15) rgb/601 in: 601 out, 709 if swapped
// (RULE16) 709 in: 709 out, 601 if swapped
// (RULE17) chosen conversion readable in readback field
// (RULE18) brightness, contrast, saturation and hue adjust
// (RULE19) preprocessor stage configured from formats, controls
// (RULE20) readback codes per conversion, 1111 manual
// (RULE21) manual coefficients thirteen bits per channel
// (RULE22) readback follows changes within two cycles
`timescale 1ns/1ns
module colour_matrix_mode_select (
  input wire logic core_clk,
  input wire logic arst_n,
  input colour_matrix_pkg::reg_req_s reg_req, // register access
  output logic [7:0] reg_rd_data, // read data, one cycle later
  output logic reg_rd_valid, // read answer strobe
  input colour_matrix_pkg::link_info_s link_info, // link colorimetry
  input wire logic [3:0] primary_format,
  input wire logic output_range_select, // 1: full range output
  input colour_matrix_pkg::coeff_t manual_coeff,
  input wire logic [1:0] manual_scale,
  input colour_matrix_pkg::adjust_s adjust,
  input colour_matrix_pkg::pixel_s pix_in,
  output colour_matrix_pkg::pixel_s pix_out,
  output colour_matrix_pkg::triple_t blank_level,
  output logic matrix_enabled,
  output logic in_full_range,
  output logic dpp_to_yuv
);

  // ==========================================================
  // helpers
  // register hit on one page and offset
  function automatic logic hit(colour_matrix_pkg::reg_req_s r,
                               logic page, logic [7:0] ofs);
    return r.page == page && r.addr == ofs;
  endfunction : hit

  // unsigned channel to signed accumulator width
  function automatic logic signed [27:0] sx(logic [11:0] v);
    return 28'(signed'({1'b0, v}));
  endfunction : sx

  // unsigned gain byte to signed accumulator width
  function automatic logic signed [27:0] ux8(logic [7:0] v);
    return 28'(signed'({1'b0, v}));
  endfunction : ux8

  // coefficient times channel
  function automatic logic signed [27:0] mul(logic signed [12:0] c,
                                             logic [11:0] p);
    logic signed [25:0] pr;
    pr = c * signed'({1'b0, p});
    return 28'(pr);
  endfunction : mul

  // saturate to the channel range
  function automatic logic [11:0] clamp(logic signed [27:0] v);
    if (v < 0) return 12'h000;
    else if (v > 28'sh0000FFF) return 12'hFFF;
    else return v[11:0];
  endfunction : clamp

  // ==========================================================
  // control registers
  logic [3:0] in_fmt; // input colour format field
  logic swap; // standard swap
  logic out_rgb; // output space select
  logic [3:0] mode_sel; // conversion mode select
  logic force_on; // matrix force on
  colour_matrix_pkg::class_e eff_cls; // effective input class
  colour_matrix_pkg::conv_e conv_rb; // selected conversion
  logic auto_mode;

  // codes other than 1111 run manual so a stray write never
  // leaves the matrix on half-derived coefficients
  assign auto_mode = mode_sel == colour_matrix_pkg::SEL_AUTO; // [RULE3]

  // software writes, one byte at a time
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_fmt <= colour_matrix_pkg::RST_IN_FMT; // [RULE9]
      swap <= colour_matrix_pkg::RST_SWAP;
      out_rgb <= colour_matrix_pkg::RST_OUT_SPACE;
      mode_sel <= colour_matrix_pkg::RST_MODE; // [RULE3]
      force_on <= colour_matrix_pkg::RST_FORCE;
    end else if (reg_req.wr) begin
      if (hit(reg_req, colour_matrix_pkg::PAGE_IO,
              colour_matrix_pkg::OFS_FORMAT)) begin
        in_fmt <= reg_req.wdata[colour_matrix_pkg::POS_IN_FMT +: 4];
        swap <= reg_req.wdata[colour_matrix_pkg::POS_SWAP];
        out_rgb <= reg_req.wdata[colour_matrix_pkg::POS_OUT_SPACE];
      end
      if (hit(reg_req, colour_matrix_pkg::PAGE_MATRIX,
              colour_matrix_pkg::OFS_MODE)) begin
        mode_sel <= reg_req.wdata[colour_matrix_pkg::POS_MODE +: 4];
      end
      if (hit(reg_req, colour_matrix_pkg::PAGE_MATRIX,
              colour_matrix_pkg::OFS_FORCE)) begin
        force_on <= reg_req.wdata[colour_matrix_pkg::POS_FORCE];
      end
    end
  end

  // reads answer the next cycle; unmapped reads give zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rd_data <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_req.rd;
      reg_rd_data <= 8'h00;
      if (reg_req.rd) begin
        if (hit(reg_req, colour_matrix_pkg::PAGE_IO,
                colour_matrix_pkg::OFS_FORMAT)) begin
          reg_rd_data[colour_matrix_pkg::POS_IN_FMT +: 4] <= in_fmt;
          reg_rd_data[colour_matrix_pkg::POS_SWAP] <= swap;
          reg_rd_data[colour_matrix_pkg::POS_OUT_SPACE] <= out_rgb;
        end
        if (hit(reg_req, colour_matrix_pkg::PAGE_MATRIX,
                colour_matrix_pkg::OFS_MODE)) begin
          reg_rd_data[colour_matrix_pkg::POS_MODE +: 4] <= mode_sel;
        end
        if (hit(reg_req, colour_matrix_pkg::PAGE_MATRIX,
                colour_matrix_pkg::OFS_FORCE)) begin
          reg_rd_data[colour_matrix_pkg::POS_FORCE] <= force_on;
        end
        if (hit(reg_req, colour_matrix_pkg::PAGE_MATRIX,
                colour_matrix_pkg::OFS_READBACK)) begin
          reg_rd_data[colour_matrix_pkg::POS_READBACK +: 4] <=
            conv_rb; // [RULE17]
        end
      end
    end
  end

  // ==========================================================
  // effective input space and range
  // undefined codes keep the last class, as software must avoid them
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eff_cls <= colour_matrix_pkg::CLS_RGB;
      in_full_range <= 1'b0;
    end else begin
      case (in_fmt) // [RULE8]
        colour_matrix_pkg::FMT_RGB_LIM,
        colour_matrix_pkg::FMT_RGB_FULL: begin
          eff_cls <= colour_matrix_pkg::CLS_RGB;
          in_full_range <= in_fmt == colour_matrix_pkg::FMT_RGB_FULL;
        end
        colour_matrix_pkg::FMT_601_LIM, colour_matrix_pkg::FMT_XV_601,
        colour_matrix_pkg::FMT_601_FULL: begin
          eff_cls <= colour_matrix_pkg::CLS_601;
          in_full_range <= in_fmt == colour_matrix_pkg::FMT_601_FULL;
        end
        colour_matrix_pkg::FMT_709_LIM, colour_matrix_pkg::FMT_XV_709,
        colour_matrix_pkg::FMT_709_FULL: begin
          eff_cls <= colour_matrix_pkg::CLS_709;
          in_full_range <= in_fmt == colour_matrix_pkg::FMT_709_FULL;
        end
        colour_matrix_pkg::FMT_FROM_LINK: begin // [RULE9]
          eff_cls <= link_info.rgb ? colour_matrix_pkg::CLS_RGB :
            link_info.is709 ? colour_matrix_pkg::CLS_709 :
            colour_matrix_pkg::CLS_601;
          // link modes: yuv always full, rgb as reported
          if ((primary_format == colour_matrix_pkg::PRIM_COMPONENT ||
               primary_format == colour_matrix_pkg::PRIM_GRAPHIC) &&
              !link_info.rgb) begin
            in_full_range <= 1'b1; // [RULE11]
          end else begin
            in_full_range <= link_info.full_range; // [RULE11]
          end
        end
        default: begin // [RULE10]
          eff_cls <= eff_cls;
          in_full_range <= in_full_range;
        end
      endcase
    end
  end

  // ==========================================================
  // conversion choice, registered as the readback
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_rb <= colour_matrix_pkg::CONV_BYPASS;
    end else if (!auto_mode) begin
      conv_rb <= colour_matrix_pkg::CONV_MANUAL; // [RULE20] [RULE7]
    end else if (out_rgb) begin // [RULE14] [RULE4]
      case (eff_cls)
        colour_matrix_pkg::CLS_601:
          conv_rb <= colour_matrix_pkg::CONV_601_RGB;
        colour_matrix_pkg::CLS_709:
          conv_rb <= colour_matrix_pkg::CONV_709_RGB;
        default: conv_rb <= colour_matrix_pkg::CONV_BYPASS;
      endcase
    end else begin
      case (eff_cls) // [RULE13] [RULE22]
        colour_matrix_pkg::CLS_601: // [RULE15]
          conv_rb <= swap ? colour_matrix_pkg::CONV_601_709 :
            colour_matrix_pkg::CONV_BYPASS;
        colour_matrix_pkg::CLS_709: // [RULE16]
          conv_rb <= swap ? colour_matrix_pkg::CONV_709_601 :
            colour_matrix_pkg::CONV_BYPASS;
        default: // [RULE15]
          conv_rb <= swap ? colour_matrix_pkg::CONV_RGB_709 :
            colour_matrix_pkg::CONV_RGB_601;
      endcase
    end
  end

  // ==========================================================
  // enable, blank levels, preprocessor setting
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      matrix_enabled <= 1'b0;
      blank_level <= '0;
      dpp_to_yuv <= 1'b0;
    end else begin
      matrix_enabled <= force_on || adjust.en || // [RULE2] [RULE1]
        conv_rb != colour_matrix_pkg::CONV_BYPASS;
      // rgb blanks all three alike; YPbPr centres the chroma
      blank_level[0] <= output_range_select ? // [RULE12] [RULE5]
        colour_matrix_pkg::BLANK_ZERO : colour_matrix_pkg::BLANK_LUMA_LIM;
      for (int i = 1; i < 3; i++) begin
        blank_level[i] <= out_rgb ? (output_range_select ?
          colour_matrix_pkg::BLANK_ZERO :
          colour_matrix_pkg::BLANK_LUMA_LIM) :
          colour_matrix_pkg::CHROMA_MID; // [RULE12]
      end
      // colour controls work in YPbPr, so rgb input is
      // converted ahead of them
      dpp_to_yuv <= adjust.en && // [RULE19]
        eff_cls == colour_matrix_pkg::CLS_RGB;
    end
  end

  // ==========================================================
  // coefficient choice
  colour_matrix_pkg::coeff_t coef; // active coefficients
  logic [1:0] scale;
  always_comb begin
    coef = manual_coeff; // [RULE21] [RULE7]
    scale = manual_scale;
    case (conv_rb) // [RULE5]
      colour_matrix_pkg::CONV_601_RGB: begin
        coef = colour_matrix_pkg::COEF_601_RGB;
        scale = colour_matrix_pkg::SCALE_ONE;
      end
      colour_matrix_pkg::CONV_709_RGB: begin
        coef = colour_matrix_pkg::COEF_709_RGB;
        scale = colour_matrix_pkg::SCALE_ONE;
      end
      colour_matrix_pkg::CONV_RGB_601: begin
        coef = colour_matrix_pkg::COEF_RGB_601;
        scale = colour_matrix_pkg::SCALE_ZERO;
      end
      colour_matrix_pkg::CONV_RGB_709: begin
        coef = colour_matrix_pkg::COEF_RGB_709;
        scale = colour_matrix_pkg::SCALE_ZERO;
      end
      colour_matrix_pkg::CONV_709_601: begin
        coef = colour_matrix_pkg::COEF_709_601;
        scale = colour_matrix_pkg::SCALE_ONE;
      end
      colour_matrix_pkg::CONV_601_709: begin
        coef = colour_matrix_pkg::COEF_601_709;
        scale = colour_matrix_pkg::SCALE_ONE;
      end
      default: ; // manual or bypass keeps software values
    endcase
  end

  // ==========================================================
  // stage 1: matrix per output channel
  colour_matrix_pkg::pixel_s s1; // matrix output
  colour_matrix_pkg::triple_t mx; // matrix result
  for (genvar ch = 0; ch < 3; ch++) begin : g_mx
    logic signed [27:0] sum;
    always_comb begin
      sum = mul(coef[4 * ch], pix_in.data[0]) +
        mul(coef[4 * ch + 1], pix_in.data[1]) +
        mul(coef[4 * ch + 2], pix_in.data[2]);
      sum = (sum >>> (colour_matrix_pkg::UNITY_SHIFT - 32'(scale))) +
        28'(signed'(coef[4 * ch + 3])); // [RULE21]
      mx[ch] = clamp(sum);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= '0;
    end else begin
      s1.valid <= pix_in.valid;
      s1.data <= matrix_enabled ? mx : pix_in.data; // [RULE1]
    end
  end

  // ==========================================================
  // stage 2: colour controls; a is luma, b and c chroma
  logic signed [27:0] db, dr, rb, rr, ya;
  always_comb begin
    db = sx(s1.data[1]) - sx(colour_matrix_pkg::CHROMA_MID);
    dr = sx(s1.data[2]) - sx(colour_matrix_pkg::CHROMA_MID);
    rb = (db * 28'(adjust.hue_cos) - dr * 28'(adjust.hue_sin))
      >>> colour_matrix_pkg::ADJ_SHIFT; // [RULE18]
    rr = (dr * 28'(adjust.hue_cos) + db * 28'(adjust.hue_sin))
      >>> colour_matrix_pkg::ADJ_SHIFT;
    ya = ((sx(s1.data[0]) * ux8(adjust.contrast))
      >>> colour_matrix_pkg::ADJ_SHIFT) +
      (28'(adjust.bright) <<< colour_matrix_pkg::BRIGHT_SHIFT);
    rb = ((rb * ux8(adjust.sat)) >>> colour_matrix_pkg::ADJ_SHIFT) +
      sx(colour_matrix_pkg::CHROMA_MID);
    rr = ((rr * ux8(adjust.sat)) >>> colour_matrix_pkg::ADJ_SHIFT) +
      sx(colour_matrix_pkg::CHROMA_MID);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pix_out <= '0;
    end else begin
      pix_out.valid <= s1.valid;
      pix_out.data <= adjust.en ? // [RULE18]
        {clamp(rr), clamp(rb), clamp(ya)} : s1.data;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_force_holds: assert property (force_on |=> matrix_enabled) // [RULE2]
    else $error("force set but matrix off");
  a_idle_passes: assert property (pix_in.valid && !matrix_enabled
    ##1 !adjust.en |=> pix_out.data == $past(pix_in.data, 2)) // [RULE1]
    else $error("idle matrix altered pixel");
  a_manual_rb: assert property (!auto_mode |=> // [RULE3]
    conv_rb == colour_matrix_pkg::CONV_MANUAL)
    else $error("manual mode not reported");
  a_output_space_select: assert property (auto_mode && out_rgb && // [RULE14]
    eff_cls == colour_matrix_pkg::CLS_709 |=>
    conv_rb == colour_matrix_pkg::CONV_709_RGB)
    else $error("rgb output not chosen");
  a_swap_601: assert property (auto_mode && !out_rgb && swap && // [RULE15]
    eff_cls == colour_matrix_pkg::CLS_601 |=>
    conv_rb == colour_matrix_pkg::CONV_601_709)
    else $error("601 swap wrong");
  a_keep_709: assert property (auto_mode && !out_rgb && !swap && // [RULE16]
    eff_cls == colour_matrix_pkg::CLS_709 |=>
    conv_rb == colour_matrix_pkg::CONV_BYPASS)
    else $error("709 passthrough wrong");
  a_forced_fmt: assert property (in_fmt == // [RULE8]
    colour_matrix_pkg::FMT_709_LIM |=> eff_cls ==
    colour_matrix_pkg::CLS_709 && !in_full_range)
    else $error("forced 709 format wrong");
  a_link_fmt: assert property (in_fmt == // [RULE9]
    colour_matrix_pkg::FMT_FROM_LINK && link_info.rgb |=>
    eff_cls == colour_matrix_pkg::CLS_RGB)
    else $error("link format not followed");
  a_rgb_blank: assert property (out_rgb |=> // [RULE12]
    blank_level[1] == blank_level[0])
    else $error("rgb blank levels differ");

  c_auto_rgb: cover property (auto_mode && out_rgb ##2 pix_out.valid);
  c_manual: cover property (!auto_mode ##2 pix_out.valid);
  c_adjust: cover property (adjust.en && pix_in.valid ##2 pix_out.valid);

endmodule : colour_matrix_mode_select

// *** hdl/colour_matrix_pkg.sv ***
// colour matrix shared definitions: register map, codes, tables, carriers
// assumes byte-wide registers on two pages and 12-bit pixel channels
package colour_matrix_pkg;

  // ==========================================================
  // register map: page, offset, field position
  localparam logic PAGE_IO = 1'b0;
  localparam logic PAGE_MATRIX = 1'b1;
  localparam logic [7:0] OFS_FORMAT = 8'h02;
  localparam logic [7:0] OFS_MODE = 8'h68;
  localparam logic [7:0] OFS_FORCE = 8'h69;
  localparam logic [7:0] OFS_READBACK = 8'hF4;
  localparam int POS_IN_FMT = 4;
  localparam int POS_SWAP = 3;
  localparam int POS_OUT_SPACE = 1;
  localparam int POS_MODE = 4;
  localparam int POS_FORCE = 4;
  localparam int POS_READBACK = 4;

  // ==========================================================
  // values after reset
  localparam logic [3:0] RST_IN_FMT = 4'hF;
  localparam logic [3:0] RST_MODE = 4'hF;
  localparam logic RST_SWAP = 1'b0;
  localparam logic RST_OUT_SPACE = 1'b0;
  localparam logic RST_FORCE = 1'b0;

  // ==========================================================
  // field codes
  localparam logic [3:0] SEL_MANUAL = 4'h0;
  localparam logic [3:0] SEL_AUTO = 4'hF;
  localparam logic [3:0] FMT_RGB_LIM = 4'h0;
  localparam logic [3:0] FMT_RGB_FULL = 4'h1;
  localparam logic [3:0] FMT_601_LIM = 4'h2;
  localparam logic [3:0] FMT_709_LIM = 4'h3;
  localparam logic [3:0] FMT_XV_601 = 4'h4;
  localparam logic [3:0] FMT_XV_709 = 4'h5;
  localparam logic [3:0] FMT_601_FULL = 4'h6;
  localparam logic [3:0] FMT_709_FULL = 4'h7;
  localparam logic [3:0] FMT_FROM_LINK = 4'hF;
  localparam logic [3:0] PRIM_COMPONENT = 4'h5;
  localparam logic [3:0] PRIM_GRAPHIC = 4'h6;

  typedef enum logic [3:0] {
    CONV_BYPASS = 4'h0, CONV_601_RGB = 4'h1, CONV_709_RGB = 4'h3,
    CONV_RGB_601 = 4'h5, CONV_RGB_709 = 4'h7, CONV_709_601 = 4'h9,
    CONV_601_709 = 4'hA, CONV_MANUAL = 4'hF
  } conv_e;

  typedef enum logic [1:0] {
    CLS_RGB = 2'h0, CLS_601 = 2'h1, CLS_709 = 2'h2
  } class_e;

  // ==========================================================
  // arithmetic constants
  localparam int UNITY_SHIFT = 12;
  localparam int ADJ_SHIFT = 7;
  localparam int BRIGHT_SHIFT = 4;
  localparam logic [11:0] BLANK_LUMA_LIM = 12'h100;
  localparam logic [11:0] BLANK_ZERO = 12'h000;
  localparam logic [11:0] CHROMA_MID = 12'h800;

  // ==========================================================
  // carriers
  typedef logic [2:0][11:0] triple_t;
  typedef logic [0:11][12:0] coeff_t;
  typedef struct packed {logic valid; triple_t data;} pixel_s;
  typedef struct packed {
    logic page; logic wr; logic rd; logic [7:0] addr; logic [7:0] wdata;
  } reg_req_s;
  typedef struct packed {logic rgb; logic is709; logic full_range;}
    link_info_s;
  typedef struct packed {
    logic en; logic [7:0] contrast; logic signed [7:0] bright;
    logic [7:0] sat; logic signed [7:0] hue_cos; logic signed [7:0] hue_sin;
  } adjust_s;

  // ==========================================================
  // automatic coefficient sets, order a1..a4 b1..b4 c1..c4
  localparam logic [1:0] SCALE_ONE = 2'b01;
  localparam logic [1:0] SCALE_ZERO = 2'b00;
  localparam coeff_t COEF_601_RGB = {13'h0800, 13'h1A6A, 13'h1D50,
    13'h0423, 13'h0800, 13'h0AF8, 13'h0000, 13'h1A84, 13'h0800,
    13'h0000, 13'h0DDB, 13'h1912};
  localparam coeff_t COEF_709_RGB = {13'h0800, 13'h1C54, 13'h1E89,
    13'h0291, 13'h0800, 13'h0C52, 13'h0000, 13'h19D7, 13'h0800,
    13'h0000, 13'h0E87, 13'h18BC};
  localparam coeff_t COEF_RGB_601 = {13'h0964, 13'h04C9, 13'h01D3,
    13'h0000, 13'h1927, 13'h082D, 13'h1EAC, 13'h0800, 13'h1A93,
    13'h1D3F, 13'h082D, 13'h0800};
  localparam coeff_t COEF_RGB_709 = {13'h0B71, 13'h0368, 13'h0127,
    13'h0000, 13'h1893, 13'h082D, 13'h1F3F, 13'h0800, 13'h19B2,
    13'h1E21, 13'h082D, 13'h0800};
  localparam coeff_t COEF_709_601 = {13'h0800, 13'h0188, 13'h00CB,
    13'h1ED7, 13'h0000, 13'h07DE, 13'h1F6C, 13'h005B, 13'h0000,
    13'h1F1D, 13'h07EB, 13'h007B};
  localparam coeff_t COEF_601_709 = {13'h0800, 13'h1E56, 13'h1F14,
    13'h014A, 13'h0000, 13'h0834, 13'h009A, 13'h1F9A, 13'h0000,
    13'h00EB, 13'h0826, 13'h1F78};

endpackage : colour_matrix_pkg

// *** verification/link_source.sv ***
// upstream link model: colorimetry report and a random pixel stream
// assumes the bench chooses the report and the primary mode
`timescale 1ns/1ns
module link_source (
  input wire logic core_clk,
  input colour_matrix_pkg::link_info_s report,
  input wire logic [3:0] mode,
  output colour_matrix_pkg::link_info_s link_info,
  output logic [3:0] primary_format,
  output colour_matrix_pkg::pixel_s pix_in
);
  // ========================================
  // reported format follows the bench at once
  assign link_info = report;
  assign primary_format = mode;
  // new pixel every cycle, launched just after the edge
  initial pix_in = '0;
  always @(posedge core_clk) begin
    pix_in <= #1 {1'b1, 36'({$urandom, $urandom})};
  end
endmodule : link_source

// *** verification/test_colour_matrix_mode_select.sv ***
// bench for the colour matrix selection logic, with a reference model
// assumes link_source on the pixel side and a 100 MHz core clock
`timescale 1ns/1ns
module test_colour_matrix_mode_select;
  logic core_clk = 0;
  logic arst_n = 0;
  colour_matrix_pkg::reg_req_s reg_req = '0;
  logic [7:0] reg_rd_data;
  logic reg_rd_valid;
  colour_matrix_pkg::link_info_s link_info, rep = '0;
  logic [3:0] prim = 0, primary_format;
  logic out_range = 0;
  colour_matrix_pkg::coeff_t coef = '0;
  colour_matrix_pkg::adjust_s adj = '0;
  colour_matrix_pkg::pixel_s pix_in, pix_out;
  colour_matrix_pkg::triple_t blank_level;
  logic matrix_enabled, in_full_range, dpp_to_yuv;
  int fmt = 15, sw = 0, osp = 0, mode = 15, frc = 0;
  int miscompares = 0, total_checks = 0, cycles = 0;
  colour_matrix_mode_select uut (.core_clk(core_clk), .arst_n(arst_n),
    .reg_req(reg_req), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .link_info(link_info),
    .primary_format(primary_format), .output_range_select(out_range),
    .manual_coeff(coef), .manual_scale(2'h1), .adjust(adj),
    .pix_in(pix_in), .pix_out(pix_out), .blank_level(blank_level),
    .matrix_enabled(matrix_enabled), .in_full_range(in_full_range),
    .dpp_to_yuv(dpp_to_yuv));
  link_source src (.core_clk(core_clk), .report(rep), .mode(prim),
    .link_info(link_info), .primary_format(primary_format),
    .pix_in(pix_in));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // ========================================
  // reference model: 0 rgb, 1 601, 2 709
  function automatic int cls_of(int f);
    if (f == 15)
      return rep.rgb ? 0 : (rep.is709 ? 2 : 1);
    return f < 2 ? 0 : (f % 2 ? 2 : 1);
  endfunction : cls_of
  function automatic int exp_conv(int c);
    if (mode != 15)
      return 15;
    if (osp)
      return c == 0 ? 0 : (c == 1 ? 1 : 3);
    if (c == 0)
      return sw ? 7 : 5;
    return sw ? (c == 1 ? 10 : 9) : 0;
  endfunction : exp_conv
  task chk(input logic [36:0] s, e, input string nm);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, s);
    end
  endtask : chk
  task wr(input logic pg, input logic [7:0] a, d);
    @(posedge core_clk) #1;
    reg_req = '{pg, 1'b1, 1'b0, a, d};
    @(posedge core_clk) #1;
    reg_req.wr = 1'b0;
  endtask : wr
  // bounded wait on the read strobe, then compare the byte
  task rd(input logic pg, input logic [7:0] a, input int e);
    @(posedge core_clk) #1;
    reg_req = '{pg, 1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk) #1;
    reg_req.rd = 1'b0;
    for (int n = 0; n < 3 && reg_rd_valid !== 1'b1; n++)
      @(posedge core_clk) #1;
    chk(reg_rd_valid, 1, "rd_valid");
    chk(reg_rd_data, e, "rd_data");
  endtask : rd
  // let the selection settle, then compare readback, enable, dpp, blank levels and range
  task check_all();
    int c, f;
    logic [11:0] b, l;
    repeat (6) @(posedge core_clk);
    #1;
    c = cls_of(fmt);
    f = (fmt == 15) ? ((prim != 0 && c != 0) ? 1 : rep.full_range)
        : (fmt == 1 || fmt > 5);
    b = out_range ? 12'h000 : 12'h100;
    l = osp ? b : 12'h800;
    rd(1'b1, 8'hF4, exp_conv(c) << 4);
    chk(matrix_enabled, frc | adj.en | (exp_conv(c) != 0), "en");
    chk(dpp_to_yuv, adj.en & (c == 0), "dpp");
    chk(blank_level, {l, l, b}, "blank");
    if (fmt != 4 && fmt != 5)
      chk(in_full_range, f, "range");
  endtask : check_all
  // saturate a model value to the channel range
  function automatic logic [11:0] sat12(int s);
    return s < 0 ? 12'h000 : (s > 4095 ? 12'hFFF : 12'(s));
  endfunction : sat12
  // matrix model: (k1*a + k2*b + k3*c) >>> (12 - scale) + k4
  function automatic colour_matrix_pkg::triple_t mat(
      colour_matrix_pkg::coeff_t k, int sc, colour_matrix_pkg::triple_t p);
    colour_matrix_pkg::triple_t r;
    int s;
    for (int ch = 0; ch < 3; ch++) begin
      s = 0;
      for (int j = 0; j < 3; j++)
        s += int'($signed(k[4 * ch + j])) * int'(p[j]);
      r[ch] = sat12((s >>> (12 - sc)) + int'($signed(k[4 * ch + 3])));
    end
    return r;
  endfunction : mat
  // colour controls model: a luma, b and c chroma about 0x800;
  // gains 0x80 stand for one, brightness counts in steps of 16
  function automatic colour_matrix_pkg::triple_t tone(
      colour_matrix_pkg::triple_t p);
    int u, v, hc, hs, y;
    hc = signed'(adj.hue_cos);
    hs = signed'(adj.hue_sin);
    u = int'(p[1]) - 2048;
    v = int'(p[2]) - 2048;
    y = ((int'(p[0]) * int'(adj.contrast)) >>> 7) +
      int'(signed'(adj.bright)) * 16;
    {u, v} = {(u * hc - v * hs) >>> 7, (v * hc + u * hs) >>> 7};
    return {sat12(((v * int'(adj.sat)) >>> 7) + 2048),
      sat12(((u * int'(adj.sat)) >>> 7) + 2048), sat12(y)};
  endfunction : tone
  // output pixel against the model of the input two cycles earlier;
  // automatic so that no pixel is left queued from an earlier call
  task automatic pix_check(input bit on, input colour_matrix_pkg::coeff_t k,
                           input int sc);
    colour_matrix_pkg::pixel_s h[$];
    colour_matrix_pkg::triple_t d;
    repeat (20) begin
      @(posedge core_clk) #2;
      d = on ? mat(k, sc, pix_in.data) : pix_in.data;
      h.push_back({pix_in.valid, adj.en ? tone(d) : d});
      if (h.size() > 2)
        chk(pix_out, h.pop_front(), "pixel");
    end
    @(posedge core_clk) #1;
  endtask : pix_check
  task complete_run();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  // ========================================
  // main sequence; undefined input formats are never written
  initial begin
    void'($urandom(64392));
    adj = '{1'b0, 8'h80, 8'sh00, 8'h80, 8'sh7F, 8'sh00};
    coef[0] = 13'h0800;
    coef[5] = 13'h0800;
    coef[10] = 13'h0800;
    repeat (10) @(posedge core_clk);
    #1;
    arst_n = 1;
    rd(1'b0, 8'h02, 8'hF0);
    rd(1'b1, 8'h68, 8'hF0);
    rd(1'b1, 8'h69, 8'h00);
    check_all();
    for (int i = 0; i < 36; i++) begin
      fmt = (i % 9 == 8) ? 15 : i % 9;
      sw = (i / 9) % 2;
      osp = i / 18;
      rep = 3'($urandom);
      prim = 4'($urandom % 3);
      prim = prim ? prim + 4 : 0;
      out_range = 1'($urandom);
      wr(1'b0, 8'h02, {fmt[3:0], sw[0], 1'b0, osp[0], 1'b0});
      check_all();
    end
    wr(1'b1, 8'h68, 8'h00);
    mode = 0;
    check_all();
    pix_check(1'b1, coef, 1);
    wr(1'b1, 8'h68, 8'h30);
    mode = 3;
    check_all();
    wr(1'b1, 8'h68, 8'hF0);
    mode = 15;
    // automatic rgb to 601 through the stored coefficient table
    wr(1'b0, 8'h02, 8'h00);
    {fmt, sw, osp} = {32'd0, 32'd0, 32'd0};
    check_all();
    pix_check(1'b1, colour_matrix_pkg::COEF_RGB_601,
              colour_matrix_pkg::SCALE_ZERO);
    wr(1'b0, 8'h02, 8'h12);
    {fmt, sw, osp} = {32'd1, 32'd0, 32'd1};
    wr(1'b1, 8'hF4, 8'hA0);
    check_all();
    pix_check(1'b0, coef, 1);
    adj.en = 1'b1;
    check_all();
    pix_check(1'b1, coef, 1);
    adj.en = 1'b0;
    wr(1'b1, 8'h69, 8'h10);
    frc = 1;
    check_all();
    rd(1'b1, 8'h10, 8'h00);
    complete_run();
  end
endmodule : test_colour_matrix_mode_select
